// File: src/bgc_pkg.sv
// package with register map, field layout and operation codes of the blit parameter bank
package bgc_pkg;

    // ---------------------------------------------------------------
    // register indices (printed offsets, byte address is four times)
    // ---------------------------------------------------------------
    localparam logic [9:0] IDX_DEST_0        = 10'h108;
    localparam logic [9:0] IDX_DEST_1        = 10'h109;
    localparam logic [9:0] IDX_DEST_2        = 10'h10a;
    localparam logic [9:0] IDX_LINE_OFS_LOW  = 10'h10c;
    localparam logic [9:0] IDX_LINE_OFS_HIGH = 10'h10d;
    localparam logic [9:0] IDX_WIDTH_LOW     = 10'h110;
    localparam logic [9:0] IDX_WIDTH_HIGH    = 10'h111;
    localparam logic [9:0] IDX_HEIGHT_LOW    = 10'h112;
    localparam logic [9:0] IDX_HEIGHT_HIGH   = 10'h113;
    localparam logic [9:0] IDX_BACK_LOW      = 10'h114;
    localparam logic [9:0] IDX_BACK_HIGH     = 10'h115;
    localparam logic [9:0] IDX_FORE_LOW      = 10'h118;
    localparam logic [9:0] IDX_FORE_HIGH     = 10'h119;
    localparam logic [9:0] IDX_CONTROL       = 10'h11c;
    localparam logic [9:0] IDX_STATUS        = 10'h11d;

    // ---------------------------------------------------------------
    // field widths and implemented-bit masks of the high bytes
    // ---------------------------------------------------------------
    localparam int         DEST_W        = 21;
    localparam int         LINE_OFS_W    = 11;
    localparam int         SIZE_W        = 10;
    localparam int         COLOUR_W      = 16;
    localparam logic [7:0] MASK_DEST_2   = 8'h1f;
    localparam logic [7:0] MASK_OFS_HIGH = 8'h07;
    localparam logic [7:0] MASK_SIZE_HI  = 8'h03;
    localparam logic [7:0] RESET_BYTE    = 8'h00;

    // control register bit positions (depth select, operation code, rectangle mode, start)
    localparam int CTL_DEPTH_BIT = 0;
    localparam int CTL_OP_LSB    = 1;
    localparam int CTL_RECT_BIT  = 5;
    localparam int CTL_START_BIT = 7;

    // ---------------------------------------------------------------
    // operation codes that decide how the colours are used
    // ---------------------------------------------------------------
    localparam logic [3:0] OP_COLOUR_EXPAND = 4'h8;
    localparam logic [3:0] OP_MOVE_EXPAND   = 4'ha;
    localparam logic [3:0] OP_SOLID_FILL    = 4'hc;

    // parameters held for one transfer
    typedef struct packed {
        logic [20:0] dest;
        logic [10:0] line_ofs;
        logic [9:0]  width;
        logic [9:0]  height;
        logic [15:0] back_colour;
        logic [15:0] fore_colour;
        logic        depth16;
        logic        rect;
        logic [3:0]  op;
    } bgc_params_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } bgc_state_t;

endpackage

// File: src/bgc_regs.sv
// blit geometry and colour parameter register bank with APB slave
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1 - hold a 21-bit destination start address for the transfer
// R2 - hold an 11-bit word offset between starts of consecutive rectangle lines
// R3 - line offset only steps blit addresses in rectangular mode, never refresh
// R4 - line offset is low byte bits 7-0 plus high byte bits 2-0
// R5 - width field is pixels minus one; pixels per line is value plus one
// R6 - width low eight bits from first register, bits 9-8 from second bits 1-0
// R7 - software programs width of at least two before pattern fills
// R8 - height field is lines minus one; bits 9-8 in second register low bits
// R9 - height built from full low byte and two bits of high byte
// R10 - background colour is expansion background and transparency key colour
// R11 - foreground colour is expansion foreground and solid-fill colour
// R12 - 16 bpp uses all colour bits; 8 bpp uses only bits 7-0
// R13 - op codes: expansion 1000, move with expansion 1010, solid fill 1100
// R14 - registers read back last write; unimplemented upper bits read zero
// R15 - parameters captured at start and held stable during the transfer
module bgc_regs
    import bgc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        STEP_PIXEL,
    input  wire logic        DONE,
    output logic             BUSY,
    output logic [20:0]      PIXEL_ADDR,
    output logic [15:0]      FORE_COLOUR,
    output logic [15:0]      BACK_COLOUR,
    output logic [3:0]       OP_CODE,
    output logic             EXPAND_OP,
    output logic             SOLID_OP,
    output logic             LINE_END,
    output logic             LAST_PIXEL
);

    initial begin
        if (ADDR_W != 12) $error("bgc_regs serves a 12-bit APB address only");
    end

    // ---------------------------------------------------------------
    // register storage
    // ---------------------------------------------------------------
    logic [7:0]  dest_0, dest_1, dest_2;
    logic [7:0]  ofs_low, ofs_high;
    logic [7:0]  width_low, width_high;
    logic [7:0]  height_low, height_high;
    logic [7:0]  back_low, back_high;
    logic [7:0]  fore_low, fore_high;
    logic [7:0]  control;
    bgc_params_t held;
    bgc_state_t  state;
    logic [9:0]  col;
    logic [9:0]  row;
    logic [20:0] line_start;
    logic [20:0] cur_addr;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire        access   = PSEL & PENABLE;
    wire [9:0]  index    = PADDR[11:2];
    wire        aligned  = (PADDR[1:0] == 2'b00);
    wire        wr_en    = access & PWRITE & aligned;
    wire [7:0]  wbyte    = PWDATA[7:0];

    function automatic logic hit(input logic [9:0] idx, input logic [9:0] want);
        hit = (idx == want);
    endfunction

    wire mapped = aligned & (hit(index, IDX_DEST_0) | hit(index, IDX_DEST_1) | hit(index, IDX_DEST_2)
                  | hit(index, IDX_LINE_OFS_LOW) | hit(index, IDX_LINE_OFS_HIGH)
                  | hit(index, IDX_WIDTH_LOW) | hit(index, IDX_WIDTH_HIGH)
                  | hit(index, IDX_HEIGHT_LOW) | hit(index, IDX_HEIGHT_HIGH)
                  | hit(index, IDX_BACK_LOW) | hit(index, IDX_BACK_HIGH)
                  | hit(index, IDX_FORE_LOW) | hit(index, IDX_FORE_HIGH)
                  | hit(index, IDX_CONTROL) | hit(index, IDX_STATUS));

    // zero-wait slave; unmapped or misaligned addresses answer with an error
    assign PREADY  = 1'b1;
    assign PSLVERR = access & ~mapped;

    // ---------------------------------------------------------------
    // register writes; only implemented bits are stored
    // ---------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dest_0      <= RESET_BYTE;
            dest_1      <= RESET_BYTE;
            dest_2      <= RESET_BYTE;
            ofs_low     <= RESET_BYTE;
            ofs_high    <= RESET_BYTE;
            width_low   <= RESET_BYTE;
            width_high  <= RESET_BYTE;
            height_low  <= RESET_BYTE;
            height_high <= RESET_BYTE;
            back_low    <= RESET_BYTE;
            back_high   <= RESET_BYTE;
            fore_low    <= RESET_BYTE;
            fore_high   <= RESET_BYTE;
            control     <= RESET_BYTE;
        end else if (wr_en) begin
            if (hit(index, IDX_DEST_0))        dest_0      <= wbyte;                   // R1
            if (hit(index, IDX_DEST_1))        dest_1      <= wbyte;                   // R1
            if (hit(index, IDX_DEST_2))        dest_2      <= wbyte & MASK_DEST_2;     // R14
            if (hit(index, IDX_LINE_OFS_LOW))  ofs_low     <= wbyte;                   // R4
            if (hit(index, IDX_LINE_OFS_HIGH)) ofs_high    <= wbyte & MASK_OFS_HIGH;   // R4
            if (hit(index, IDX_WIDTH_LOW))     width_low   <= wbyte;                   // R6
            if (hit(index, IDX_WIDTH_HIGH))    width_high  <= wbyte & MASK_SIZE_HI;    // R6
            if (hit(index, IDX_HEIGHT_LOW))    height_low  <= wbyte;                   // R9
            if (hit(index, IDX_HEIGHT_HIGH))   height_high <= wbyte & MASK_SIZE_HI;    // R8
            if (hit(index, IDX_BACK_LOW))      back_low    <= wbyte;                   // R10
            if (hit(index, IDX_BACK_HIGH))     back_high   <= wbyte;                   // R10
            if (hit(index, IDX_FORE_LOW))      fore_low    <= wbyte;                   // R11
            if (hit(index, IDX_FORE_HIGH))     fore_high   <= wbyte;                   // R11
            if (hit(index, IDX_CONTROL))       control     <= {1'b0, wbyte[6:0]};      // start self-clears
        end
    end

    // ---------------------------------------------------------------
    // read mux; bytes sit in bits 7-0, the rest read zero
    // ---------------------------------------------------------------
    wire [7:0] status_byte = {7'h00, (state == ST_BUSY)};
    logic [7:0] rbyte;
    always_comb begin
        rbyte = 8'h00;
        case (index)
            IDX_DEST_0:        rbyte = dest_0;
            IDX_DEST_1:        rbyte = dest_1;
            IDX_DEST_2:        rbyte = dest_2;
            IDX_LINE_OFS_LOW:  rbyte = ofs_low;
            IDX_LINE_OFS_HIGH: rbyte = ofs_high;
            IDX_WIDTH_LOW:     rbyte = width_low;
            IDX_WIDTH_HIGH:    rbyte = width_high;
            IDX_HEIGHT_LOW:    rbyte = height_low;
            IDX_HEIGHT_HIGH:   rbyte = height_high;
            IDX_BACK_LOW:      rbyte = back_low;
            IDX_BACK_HIGH:     rbyte = back_high;
            IDX_FORE_LOW:      rbyte = fore_low;
            IDX_FORE_HIGH:     rbyte = fore_high;
            IDX_CONTROL:       rbyte = control;
            IDX_STATUS:        rbyte = status_byte;
            default:           rbyte = 8'h00;
        endcase
    end
    // R14
    assign PRDATA = (access & ~PWRITE & mapped) ? {24'h000000, rbyte} : 32'h00000000;

    // ---------------------------------------------------------------
    // assembled fields as currently programmed
    // ---------------------------------------------------------------
    wire start_req = wr_en & hit(index, IDX_CONTROL) & wbyte[CTL_START_BIT];
    bgc_params_t live;
    assign live.dest        = {dest_2[4:0], dest_1, dest_0};          // R1
    assign live.line_ofs    = {ofs_high[2:0], ofs_low};               // R2 R4
    assign live.width       = {width_high[1:0], width_low};           // R6
    assign live.height      = {height_high[1:0], height_low};         // R8 R9
    assign live.back_colour = {back_high, back_low};
    assign live.fore_colour = {fore_high, fore_low};
    assign live.depth16     = wbyte[CTL_DEPTH_BIT];
    assign live.rect        = wbyte[CTL_RECT_BIT];
    assign live.op          = wbyte[CTL_OP_LSB +: 4];

    // ---------------------------------------------------------------
    // transfer sequencer: captures parameters, walks the rectangle
    // ---------------------------------------------------------------
    wire last_col  = (col == held.width);                             // R5
    wire last_row  = (row == held.height);                            // R8
    wire step      = (state == ST_BUSY) & STEP_PIXEL;
    // rectangular mode strides by the line offset; otherwise lines pack end to end
    wire [20:0] next_line = held.rect ? line_start + {10'h000, held.line_ofs}  // R3
                                      : cur_addr + 21'h000001;
    bgc_state_t next_state;
    always_comb begin
        case (state)
            ST_IDLE: next_state = start_req ? ST_BUSY : ST_IDLE;
            ST_BUSY: next_state = (DONE | (step & last_col & last_row)) ? ST_IDLE : ST_BUSY;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state      <= ST_IDLE;
            held       <= '0;
            col        <= 10'h000;
            row        <= 10'h000;
            line_start <= 21'h000000;
            cur_addr   <= 21'h000000;
        end else begin
            state <= next_state;
            if (state == ST_IDLE && start_req) begin
                // a snapshot lets software reprogram for the next job meanwhile
                held       <= live;                                   // R15
                col        <= 10'h000;
                row        <= 10'h000;
                line_start <= live.dest;
                cur_addr   <= live.dest;
            end else if (step) begin
                if (last_col) begin
                    col        <= 10'h000;
                    row        <= row + 10'h001;
                    line_start <= next_line;
                    cur_addr   <= next_line;
                end else begin
                    col      <= col + 10'h001;
                    cur_addr <= cur_addr + 21'h000001;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // colour and operation outputs, 8 bpp masks the upper byte
    // ---------------------------------------------------------------
    wire [15:0] depth_mask = held.depth16 ? 16'hffff : 16'h00ff;     // R12
    assign FORE_COLOUR = held.fore_colour & depth_mask;               // R11 R12
    assign BACK_COLOUR = held.back_colour & depth_mask;               // R10 R12
    assign OP_CODE     = held.op;
    assign EXPAND_OP   = (held.op == OP_COLOUR_EXPAND) | (held.op == OP_MOVE_EXPAND);  // R13
    assign SOLID_OP    = (held.op == OP_SOLID_FILL);                  // R13
    assign BUSY        = (state == ST_BUSY);
    assign PIXEL_ADDR  = cur_addr;
    assign LINE_END    = BUSY & last_col;
    assign LAST_PIXEL  = BUSY & last_col & last_row;

endmodule
`default_nettype wire

// File: tb/bgc_regs_props.sv
// checker of the blit parameter bank port behaviour
`timescale 1ns/1ps
`default_nettype none
module bgc_regs_props
    import bgc_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        STEP_PIXEL,
    input wire logic        DONE,
    input wire logic        BUSY,
    input wire logic [20:0] PIXEL_ADDR,
    input wire logic [15:0] FORE_COLOUR,
    input wire logic [15:0] BACK_COLOUR,
    input wire logic [3:0]  OP_CODE,
    input wire logic        EXPAND_OP,
    input wire logic        SOLID_OP,
    input wire logic        LAST_PIXEL,
    input wire logic        LINE_END
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // ------
    // start decode; depth bit is not on a port, so keep a copy
    // ------
    wire logic access     = PSEL && PENABLE;
    wire logic start_idle = access && PWRITE && PADDR == {IDX_CONTROL, 2'b00} && PWDATA[7] && !BUSY;
    logic      depth_cap;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N)
            depth_cap <= 1'b0;
        else if (start_idle)
            depth_cap <= PWDATA[0];
    end
    sequence s_start;
        start_idle;
    endsequence
    sequence s_run2;
        BUSY ##1 BUSY;
    endsequence
    a_ready_zero_wait: assert property (access |-> PREADY)
        else $error("ready low in access phase");
    a_misalign_err: assert property (access && PADDR[1:0] != 2'b00 |-> PSLVERR && PRDATA == 32'h0)
        else $error("misaligned access not refused");
    a_read_upper_zero: assert property (access && !PWRITE |-> PRDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_start_busy: assert property (s_start |=> BUSY)
        else $error("start did not raise busy");
    a_params_hold: assert property (s_run2 |-> $stable(FORE_COLOUR) && $stable(BACK_COLOUR) && $stable(OP_CODE))
        else $error("parameters moved during transfer");
    a_depth8_mask: assert property (BUSY && !depth_cap |-> FORE_COLOUR[15:8] == 8'h0 && BACK_COLOUR[15:8] == 8'h0)
        else $error("upper colour byte used in 8 bpp");
    a_op_decode: assert property ((EXPAND_OP == (OP_CODE == 4'h8 || OP_CODE == 4'ha)) && (SOLID_OP == (OP_CODE == 4'hc)))
        else $error("operation decode wrong");
    a_step_advance: assert property (BUSY && STEP_PIXEL && !LINE_END && !DONE |=> PIXEL_ADDR == $past(PIXEL_ADDR) + 21'h1)
        else $error("address did not step by one");
    a_last_idle: assert property (BUSY && STEP_PIXEL && LAST_PIXEL |=> !BUSY)
        else $error("busy after last pixel");
    a_done_idle: assert property (BUSY && DONE |=> !BUSY)
        else $error("busy after done");
endmodule
bind bgc_regs bgc_regs_props u_props (
    .CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .STEP_PIXEL(STEP_PIXEL),
    .DONE(DONE), .BUSY(BUSY), .PIXEL_ADDR(PIXEL_ADDR), .FORE_COLOUR(FORE_COLOUR), .BACK_COLOUR(BACK_COLOUR),
    .OP_CODE(OP_CODE), .EXPAND_OP(EXPAND_OP), .SOLID_OP(SOLID_OP), .LAST_PIXEL(LAST_PIXEL), .LINE_END(LINE_END)
);
`default_nettype wire

// File: tb/bgc_regs_tb_top.sv
// self-checking bench of the blit parameter bank
`timescale 1ns/1ps
`default_nettype none
module bgc_regs_tb_top
    import bgc_pkg::*;
;
    typedef struct packed {
        logic [9:0] idx;
        logic [7:0] wr;
        logic [7:0] rd;
    } bgc_row_t;
    // write value beside expected read value; high bytes lose unimplemented bits
    localparam bgc_row_t ROWS [13] = '{
        '{IDX_DEST_0, 8'ha5, 8'ha5}, '{IDX_DEST_1, 8'h5a, 8'h5a}, '{IDX_DEST_2, 8'hff, 8'h1f},
        '{IDX_LINE_OFS_LOW, 8'hc3, 8'hc3}, '{IDX_LINE_OFS_HIGH, 8'hff, 8'h07}, '{IDX_WIDTH_LOW, 8'h3c, 8'h3c},
        '{IDX_WIDTH_HIGH, 8'hfe, 8'h02}, '{IDX_HEIGHT_LOW, 8'h96, 8'h96}, '{IDX_HEIGHT_HIGH, 8'hfd, 8'h01},
        '{IDX_BACK_LOW, 8'h12, 8'h12}, '{IDX_BACK_HIGH, 8'h34, 8'h34}, '{IDX_FORE_LOW, 8'h56, 8'h56},
        '{IDX_FORE_HIGH, 8'h78, 8'h78}};
    // transfer setup: dest 1aabcd, offset 140, 3 x 2 pixels, back 2211, fore beef
    localparam bgc_row_t PRG [13] = '{
        '{IDX_DEST_0, 8'hcd, 8'h0}, '{IDX_DEST_1, 8'hab, 8'h0}, '{IDX_DEST_2, 8'h1a, 8'h0},
        '{IDX_LINE_OFS_LOW, 8'h40, 8'h0}, '{IDX_LINE_OFS_HIGH, 8'h01, 8'h0}, '{IDX_WIDTH_LOW, 8'h02, 8'h0},
        '{IDX_WIDTH_HIGH, 8'h00, 8'h0}, '{IDX_HEIGHT_LOW, 8'h01, 8'h0}, '{IDX_HEIGHT_HIGH, 8'h00, 8'h0},
        '{IDX_BACK_LOW, 8'h11, 8'h0}, '{IDX_BACK_HIGH, 8'h22, 8'h0}, '{IDX_FORE_LOW, 8'hef, 8'h0},
        '{IDX_FORE_HIGH, 8'hbe, 8'h0}};
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, step, done, busy, err;
    logic        expand_op, solid_op, line_end, last_pix;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [20:0] pix_addr;
    logic [15:0] fore, back;
    logic [3:0]  op;
    int          fail_count;
    int          n_compared;
    bgc_regs u_dut (
        .CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .STEP_PIXEL(step), .DONE(done),
        .BUSY(busy), .PIXEL_ADDR(pix_addr), .FORE_COLOUR(fore), .BACK_COLOUR(back), .OP_CODE(op),
        .EXPAND_OP(expand_op), .SOLID_OP(solid_op), .LINE_END(line_end), .LAST_PIXEL(last_pix));
    task automatic test_done;
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ------
    // apb master; the wait for pready is bounded so a stuck slave ends the run
    // ------
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [1:0] lo, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, lo};
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fail_count++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // one transfer of 3 x 2 pixels; at3 is the address expected after three steps
    task automatic xfer(input logic rect, input logic [3:0] opc, input logic dep, input logic [20:0] at3);
        int k;
        int lines;
        foreach (PRG[i]) apb(1'b1, PRG[i].idx, 2'b00, PRG[i].wr);
        apb(1'b1, IDX_CONTROL, 2'b00, {1'b1, 1'b0, rect, opc, dep});
        #1;
        chk({11'h0, pix_addr}, 32'h1aabcd);
        chk({16'h0, back}, dep ? 32'h2211 : 32'h11);
        chk({30'h0, expand_op, solid_op}, {30'h0, opc == 4'h8 || opc == 4'ha, opc == 4'hc});
        // a rewrite while busy must not reach the captured colour
        apb(1'b1, IDX_FORE_LOW, 2'b00, 8'h00);
        #1;
        chk({16'h0, fore}, dep ? 32'hbeef : 32'hef);
        chk({28'h0, op}, {28'h0, opc});
        apb(1'b0, IDX_STATUS, 2'b00, 8'h00);
        chk(rd, 32'h1);
        // steps change on a clock edge; the #1 only lets outputs settle before they are looked at
        @(posedge clk);
        step <= 1'b1;
        k = 0;
        lines = 0;
        #1;
        while (busy === 1'b1 && k < 64) begin
            if (line_end === 1'b1) lines++;
            if (k == 3) chk({11'h0, pix_addr}, {11'h0, at3});
            if (k == 2 || k == 5) chk({31'h0, last_pix}, {31'h0, k == 5});
            @(posedge clk);
            #1;
            k++;
        end
        @(posedge clk);
        step <= 1'b0;
        chk(k, 6);
        chk(lines, 2);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rst_n, psel, penable, pwrite, step, done} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        fail_count = 0;
        n_compared = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // write every row first, then read all back so cross-talk shows up
        foreach (ROWS[i]) apb(1'b1, ROWS[i].idx, 2'b00, ROWS[i].wr);
        foreach (ROWS[i]) begin
            apb(1'b0, ROWS[i].idx, 2'b00, 8'h00);
            chk(rd, {24'h0, ROWS[i].rd});
            chk({31'h0, err}, 32'h0);
        end
        // second reset in mid-run clears the bank
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, IDX_FORE_HIGH, 2'b00, 8'h00);
        chk(rd, 32'h0);
        apb(1'b0, IDX_WIDTH_LOW, 2'b01, 8'h00);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 10'h10b, 2'b00, 8'h77);
        chk({31'h0, err}, 32'h1);
        xfer(1'b0, OP_SOLID_FILL, 1'b0, 21'h1aabd0);
        xfer(1'b1, OP_MOVE_EXPAND, 1'b1, 21'h1aad0d);
        // abort with done on the first busy cycle, before any pixel step
        apb(1'b1, IDX_CONTROL, 2'b00, 8'h91);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        #1;
        chk({31'h0, busy}, 32'h0);
        chk({30'h0, expand_op, solid_op}, 32'h2);
        // start bit is a pulse, the other control bits read back
        apb(1'b0, IDX_CONTROL, 2'b00, 8'h00);
        chk(rd, 32'h11);
        test_done();
    end
endmodule
`default_nettype wire
